//--- core/bscs_defs.svh
/*
  Timing and limit constants of the buck soft-start and sync controller.
  Assumes a 200 MHz system clock; every cycle count is derived from the
  printed time or frequency by an expression.
*/
`ifndef BSCS_DEFS_SVH
`define BSCS_DEFS_SVH

// system clock rate
`define BSCS_CLK_MHZ        200
`define BSCS_CLK_KHZ        (`BSCS_CLK_MHZ * 1000)

// soft-start ramp length in switching cycles
`define BSCS_SS_STEPS       1024

// minimum controllable on time, least time rounds up
`define BSCS_TON_MIN_NS     135
`define BSCS_TON_MIN_CYC    ((`BSCS_TON_MIN_NS * `BSCS_CLK_MHZ + 999) / 1000)

// resistor-set frequency limits (shortest period rounds up)
`define BSCS_FSW_MIN_KHZ    100
`define BSCS_FSW_MAX_KHZ    2500
`define BSCS_RT_PER_MAX     (`BSCS_CLK_KHZ / `BSCS_FSW_MIN_KHZ)
`define BSCS_RT_PER_MIN     ((`BSCS_CLK_KHZ + `BSCS_FSW_MAX_KHZ - 1) / `BSCS_FSW_MAX_KHZ)

// accepted external clock range
`define BSCS_SYNC_MIN_KHZ   160
`define BSCS_SYNC_MAX_KHZ   2300
`define BSCS_SYNC_PER_MAX   (`BSCS_CLK_KHZ / `BSCS_SYNC_MIN_KHZ)
`define BSCS_SYNC_PER_MIN   ((`BSCS_CLK_KHZ + `BSCS_SYNC_MAX_KHZ - 1) / `BSCS_SYNC_MAX_KHZ)
// no falling edge for this long means the clock is gone
`define BSCS_SYNC_LOSS_CYC  (2 * `BSCS_SYNC_PER_MAX)

// fallback frequency while leaving synchronized mode
`define BSCS_FALL_KHZ       150
`define BSCS_FALL_PER       (`BSCS_CLK_KHZ / `BSCS_FALL_KHZ)

// lock deadline after entering synchronized mode
`define BSCS_LOCK_US        78
`define BSCS_LOCK_CYC       (`BSCS_LOCK_US * `BSCS_CLK_MHZ)

// time for the pin bias to settle again
`define BSCS_BIAS_US        10
`define BSCS_BIAS_CYC       (`BSCS_BIAS_US * `BSCS_CLK_MHZ)

`endif

//--- core/bscs_pkg.sv
/*
  Types of the buck soft-start and sync controller.
  Assumes nothing beyond the defs header for its constants.
*/
package bscs_pkg;

  // oscillator period in system clock cycles
  typedef logic [11:0] bscs_per_t;

  // timing pin operating mode
  typedef enum logic [1:0] {
    MODE_RES,
    MODE_ACQ,
    MODE_LOCK,
    MODE_FALL
  } bscs_mode_e;

endpackage

//--- core/bscs_osc_if.sv
/*
  Carrier between the controller and its switching oscillator.
  Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
interface bscs_osc_if;
  import bscs_pkg::*;

  bscs_per_t period;
  logic      use_ext;
  logic      ext_edge;
  logic      tick;

  modport osc (input period, input use_ext, input ext_edge, output tick);
  modport ctl (output period, output use_ext, output ext_edge, input tick);
endinterface

//--- core/bscs_sync3.sv
/*
  Three-stage input synchroniser, one lane per bit.
  Assumes inputs are asynchronous to the clock; a bit changes at the
  output once the second and third stages agree.
*/
`timescale 1ns/1ps
module bscs_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] q_next;

  // per-bit agreement of the last two stages
  assign agree  = ~(s2_reg ^ s3_reg);
  assign q_next = (agree & s3_reg) | (~agree & q_o);

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_o    <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_o    <= q_next;
    end
  end

endmodule

//--- core/bscs_osc.sv
/*
  Switching oscillator: one-cycle tick per period, or per external edge.
  Assumes the controller supplies a period within limits and an edge
  pulse already aligned to the system clock.
*/
`timescale 1ns/1ps
`include "bscs_defs.svh"
module bscs_osc
  import bscs_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // oscillator control and tick
  bscs_osc_if.osc   osc
);

  bscs_per_t cnt_reg;
  bscs_per_t cnt_next;
  logic      tick_reg;
  logic      wrap;

  // free-running wrap, or the external edge when following a clock
  assign wrap     = (cnt_reg >= osc.period - 12'h001);
  assign cnt_next = (osc.use_ext || wrap) ? 12'h000 : cnt_reg + 12'h001;
  assign osc.tick = tick_reg;

  // period counter and registered tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= 12'h000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= osc.use_ext ? osc.ext_edge : wrap;
    end
  end

endmodule

//--- core/bscs_ctrl.sv
/*
  Digital control of a step-down regulator: soft-start ramp, peak-current
  cycle end, frequency foldback, sync-pin mode switching and overvoltage
  hysteresis gating of the high-side switch.
  Assumes analog comparators deliver levels on pins, asynchronous to the
  200 MHz clock; the timing resistor arrives as a quasi-static period code.
*/
`timescale 1ns/1ps
`include "bscs_defs.svh"
module bscs_ctrl
  import bscs_pkg::*;
#(
  parameter int unsigned LOCK_CYC = `BSCS_LOCK_CYC
) (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  // enable and protection comparators
  input  wire logic        ENABLE_I,
  input  wire logic        THERMAL_TRIP_I,
  input  wire logic        OVERVOLTAGE_GUARD_RISE_I,
  input  wire logic        OVERVOLTAGE_GUARD_CLEAR_I,
  // current loop and feedback
  input  wire logic        PEAK_CURRENT_I,
  input  wire logic [1:0]  FEEDBACK_SENSE_LEVEL_I,
  // timing resistor code and sync pin
  input  wire logic [10:0] RT_PERIOD_I,
  input  wire logic        TIMING_SYNC_PIN_I,
  // switch drive and status
  output logic             SWITCH_NODE_DRIVE_O,
  output logic             TIMING_SYNC_BIAS_EN_O,
  output logic [10:0]      SS_REF_O,
  output logic             SYNC_LOCKED_O,
  output logic             CYCLE_START_O,
  output logic [1:0]       FOLD_SHIFT_O
);

  // synchronised pin levels
  logic [5:0]  flags_s;
  logic [12:0] codes_s;
  logic        en_s;
  logic        therm_s;
  logic        ov_rise_s;
  logic        ov_clear_s;
  logic        peak_s;
  logic        sync_s;
  logic [1:0]  fb_lvl_s;
  logic [10:0] rt_s;

  bscs_sync3 #(
    .WIDTH (6)
  ) u_flag_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     ({ENABLE_I, THERMAL_TRIP_I, OVERVOLTAGE_GUARD_RISE_I,
               OVERVOLTAGE_GUARD_CLEAR_I, PEAK_CURRENT_I,
               TIMING_SYNC_PIN_I}),
    .q_o     (flags_s)
  );

  bscs_sync3 #(
    .WIDTH (13)
  ) u_code_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     ({FEEDBACK_SENSE_LEVEL_I, RT_PERIOD_I}),
    .q_o     (codes_s)
  );

  // split synchronised inputs
  assign en_s       = flags_s[5];
  assign therm_s    = flags_s[4];
  assign ov_rise_s  = flags_s[3];
  assign ov_clear_s = flags_s[2];
  assign peak_s     = flags_s[1];
  assign sync_s     = flags_s[0];
  assign fb_lvl_s   = codes_s[12:11];
  assign rt_s       = codes_s[10:0];

  // run permission: enable high and die not over temperature
  logic run_ok;
  assign run_ok = en_s & ~therm_s;

  // ------------------------------------------------------------------
  // external clock edge finding and period measurement
  // ------------------------------------------------------------------
  logic      sync_q_reg;
  bscs_per_t meas_reg;
  bscs_per_t meas_next;
  logic      sync_fall;
  logic      sync_rise;
  logic      meas_ok;
  logic      sync_lost;

  // edges of the synchronised pin level
  assign sync_fall = sync_q_reg & ~sync_s;
  assign sync_rise = ~sync_q_reg & sync_s;

  // period between falling edges must lie in the accepted range
  assign meas_ok   = (meas_reg >= 12'(`BSCS_SYNC_PER_MIN)) &&
                     (meas_reg <= 12'(`BSCS_SYNC_PER_MAX));
  assign sync_lost = (meas_reg >= 12'(`BSCS_SYNC_LOSS_CYC));
  assign meas_next = sync_fall ? 12'h001 :
                     (meas_reg == 12'hfff) ? meas_reg :
                     meas_reg + 12'h001;

  // edge history and measurement counter
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync_q_reg <= 1'b0;
      meas_reg   <= 12'h000;
    end else begin
      sync_q_reg <= sync_s;
      meas_reg   <= meas_next;
    end
  end

  // ------------------------------------------------------------------
  // timing pin mode machine
  // ------------------------------------------------------------------
  bscs_mode_e mode_reg;
  bscs_mode_e mode_next;
  logic       prev_ok_reg;
  logic       prev_ok_next;
  logic [15:0] tmr_reg;
  logic [15:0] tmr_next;
  logic       lock_late;
  logic       bias_done;

  // acquisition deadline and bias settle time
  assign lock_late = (tmr_reg >= 16'(LOCK_CYC - 1));
  assign bias_done = (tmr_reg >= 16'(`BSCS_BIAS_CYC - 1));

  // next mode; lock needs two in-range periods back to back
  always_comb begin
    mode_next    = mode_reg;
    prev_ok_next = prev_ok_reg;
    tmr_next     = tmr_reg + 16'h0001;
    unique case (mode_reg)
      MODE_RES: begin
        tmr_next     = 16'h0000;
        prev_ok_next = 1'b0;
        if (sync_rise) begin
          mode_next = MODE_ACQ;
        end
      end
      MODE_ACQ: begin
        if (sync_fall) begin
          prev_ok_next = meas_ok;
          if (meas_ok && prev_ok_reg) begin
            mode_next = MODE_LOCK;
          end
        end
        if (lock_late && mode_next == MODE_ACQ) begin
          mode_next = MODE_FALL;
          tmr_next  = 16'h0000;
        end
      end
      MODE_LOCK: begin
        tmr_next = 16'h0000;
        if (sync_lost) begin
          mode_next = MODE_FALL;
        end else if (sync_fall && !meas_ok) begin
          mode_next    = MODE_ACQ;
          prev_ok_next = 1'b0;
        end
      end
      MODE_FALL: begin
        if (bias_done) begin
          mode_next = MODE_RES;
          tmr_next  = 16'h0000;
        end
      end
    endcase
  end

  // mode state, bias drive and lock flag
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mode_reg              <= MODE_RES;
      prev_ok_reg           <= 1'b0;
      tmr_reg               <= 16'h0000;
      TIMING_SYNC_BIAS_EN_O <= 1'b1;
      SYNC_LOCKED_O         <= 1'b0;
    end else begin
      mode_reg              <= mode_next;
      prev_ok_reg           <= prev_ok_next;
      tmr_reg               <= tmr_next;
      TIMING_SYNC_BIAS_EN_O <= (mode_next == MODE_RES);
      SYNC_LOCKED_O         <= (mode_next == MODE_LOCK);
    end
  end

  // ------------------------------------------------------------------
  // oscillator period selection
  // ------------------------------------------------------------------
  bscs_osc_if osc_if ();
  bscs_per_t  rt_per;

  // resistor code clamped to the supported frequency span
  assign rt_per = ({1'b0, rt_s} < 12'(`BSCS_RT_PER_MIN)) ?
                    12'(`BSCS_RT_PER_MIN) :
                  ({1'b0, rt_s} > 12'(`BSCS_RT_PER_MAX)) ?
                    12'(`BSCS_RT_PER_MAX) : {1'b0, rt_s};

  // fallback runs at the fixed low rate until bias is back
  assign osc_if.period   = (mode_reg == MODE_FALL) ?
                           12'(`BSCS_FALL_PER) : rt_per;
  // locked: each falling edge starts a tick
  assign osc_if.use_ext  = (mode_reg == MODE_LOCK);
  assign osc_if.ext_edge = sync_fall;

  bscs_osc u_osc (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESET_N_I),
    .osc     (osc_if.osc)
  );

  // ------------------------------------------------------------------
  // digital frequency foldback
  // ------------------------------------------------------------------
  logic [2:0] fold_cnt_reg;
  logic [2:0] fold_mask;
  logic [1:0] fold_shift;
  logic       cycle_start;

  // level 3 is nominal regulation, level 0 is near zero feedback
  assign fold_shift  = 2'h3 - fb_lvl_s;
  assign fold_mask   = 3'((4'h1 << fold_shift) - 4'h1);
  // divide the tick train so starts stay on oscillator edges
  assign cycle_start = osc_if.tick &
                       ((fold_cnt_reg & fold_mask) == 3'h0);

  // tick counter for the divider
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fold_cnt_reg <= 3'h0;
      FOLD_SHIFT_O <= 2'h0;
      CYCLE_START_O <= 1'b0;
    end else begin
      if (osc_if.tick) begin
        fold_cnt_reg <= fold_cnt_reg + 3'h1;
      end
      FOLD_SHIFT_O  <= fold_shift;
      CYCLE_START_O <= cycle_start;
    end
  end

  // ------------------------------------------------------------------
  // overvoltage hysteresis
  // ------------------------------------------------------------------
  logic ovp_reg;
  logic ovp_next;

  // rise comparator sets, clear comparator releases; set wins
  assign ovp_next = ov_rise_s | (ovp_reg & ~ov_clear_s);

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ovp_reg <= 1'b0;
    end else begin
      ovp_reg <= ovp_next;
    end
  end

  // ------------------------------------------------------------------
  // high-side switch pulse
  // ------------------------------------------------------------------
  logic [7:0] on_cnt_reg;
  logic [7:0] on_cnt_next;
  logic       hs_next;
  logic       min_done;
  logic       block_hs;

  // minimum on time reached; current trip ignored before it
  assign min_done = (on_cnt_reg >= 8'(`BSCS_TON_MIN_CYC - 1));
  assign block_hs = ~run_ok | ov_rise_s | ovp_reg;

  // turn on at a cycle start, off on peak current after minimum
  always_comb begin
    hs_next     = SWITCH_NODE_DRIVE_O;
    on_cnt_next = min_done ? on_cnt_reg : on_cnt_reg + 8'h01;
    if (block_hs) begin
      hs_next     = 1'b0;
      on_cnt_next = 8'h00;
    end else if (cycle_start) begin
      // current already at the control level: skip this pulse
      hs_next     = ~peak_s;
      on_cnt_next = 8'h00;
    end else if (SWITCH_NODE_DRIVE_O && min_done && peak_s) begin
      hs_next = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SWITCH_NODE_DRIVE_O <= 1'b0;
      on_cnt_reg          <= 8'h00;
    end else begin
      SWITCH_NODE_DRIVE_O <= hs_next;
      on_cnt_reg          <= on_cnt_next;
    end
  end

  // ------------------------------------------------------------------
  // soft-start reference counter
  // ------------------------------------------------------------------
  logic [10:0] ss_next;
  logic        ss_full;

  // one step per switching cycle, held at full scale
  assign ss_full = (SS_REF_O >= 11'(`BSCS_SS_STEPS));
  assign ss_next = ~run_ok ? 11'h000 :
                   (cycle_start && !ss_full) ? SS_REF_O + 11'h001 :
                   SS_REF_O;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SS_REF_O <= 11'h000;
    end else begin
      SS_REF_O <= ss_next;
    end
  end

endmodule

//--- tb/bscs_ctrl_monitor.sv
/*
  Port checker of the buck soft-start and sync controller.
  Assumes one clock domain; bound into bscs_ctrl, sees its ports only.
*/
`timescale 1ns/1ps
module bscs_ctrl_monitor #(
  parameter int unsigned LOCK_CYC = 15600
) (
  // clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_N_I,
  // enable and protection
  input wire logic        ENABLE_I,
  input wire logic        THERMAL_TRIP_I,
  input wire logic        OVERVOLTAGE_GUARD_RISE_I,
  input wire logic        OVERVOLTAGE_GUARD_CLEAR_I,
  // loop and timing inputs
  input wire logic        PEAK_CURRENT_I,
  input wire logic [1:0]  FEEDBACK_SENSE_LEVEL_I,
  input wire logic [10:0] RT_PERIOD_I,
  input wire logic        TIMING_SYNC_PIN_I,
  // design outputs
  input wire logic        SWITCH_NODE_DRIVE_O,
  input wire logic        TIMING_SYNC_BIAS_EN_O,
  input wire logic [10:0] SS_REF_O,
  input wire logic        SYNC_LOCKED_O,
  input wire logic        CYCLE_START_O,
  input wire logic [1:0]  FOLD_SHIFT_O
);
  logic [11:0] on_cnt_reg;
  logic [3:0]  calm_reg;
  logic [16:0] acq_cnt_reg;
  wire         calm;
  wire  [11:0] on_cnt_next;
  wire  [3:0]  calm_next;
  wire  [16:0] acq_cnt_next;

  // on time since start, quiet inputs, time spent acquiring
  assign calm = ENABLE_I & ~THERMAL_TRIP_I & ~OVERVOLTAGE_GUARD_RISE_I
              & OVERVOLTAGE_GUARD_CLEAR_I;
  assign on_cnt_next = CYCLE_START_O ? 12'h001 :
                       !SWITCH_NODE_DRIVE_O ? 12'h000 :
                       on_cnt_reg + {11'h000, on_cnt_reg != 12'hfff};
  assign calm_next = !calm ? 4'h0 : calm_reg + {3'h0, calm_reg != 4'hf};
  assign acq_cnt_next = (TIMING_SYNC_BIAS_EN_O | SYNC_LOCKED_O) ?
                        17'h00000 : acq_cnt_reg + 17'h00001;

  // helper counters
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      on_cnt_reg  <= 12'h000;
      calm_reg    <= 4'h0;
      acq_cnt_reg <= 17'h00000;
    end else begin
      on_cnt_reg  <= on_cnt_next;
      calm_reg    <= calm_next;
      acq_cnt_reg <= acq_cnt_next;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // steps of overvoltage latching and of the first pin crossing
  sequence ov_set;
    OVERVOLTAGE_GUARD_RISE_I [*6];
  endsequence
  sequence ov_wait;
    (!OVERVOLTAGE_GUARD_CLEAR_I) [*8];
  endsequence
  sequence pin_cross;
    TIMING_SYNC_BIAS_EN_O && TIMING_SYNC_PIN_I ##1 TIMING_SYNC_PIN_I [*8];
  endsequence

  a_enable_stop: assert property (
    (!ENABLE_I) [*7] |-> SS_REF_O == 11'h000 && !SWITCH_NODE_DRIVE_O)
    else $error("enable low did not stop switching and clear ramp");
  a_thermal_stop: assert property (
    THERMAL_TRIP_I [*7] |-> SS_REF_O == 11'h000 && !SWITCH_NODE_DRIVE_O)
    else $error("thermal trip did not stop switching and clear ramp");
  a_ramp_step: assert property (
    $changed(SS_REF_O) && SS_REF_O != 11'h000 |->
      SS_REF_O == $past(SS_REF_O) + 11'h001)
    else $error("soft-start reference moved by other than one step");
  a_ramp_ceiling: assert property (
    SS_REF_O <= 11'h400)
    else $error("soft-start reference above full scale");
  a_min_on: assert property (
    $fell(SWITCH_NODE_DRIVE_O) && calm_reg == 4'hf |->
      $past(on_cnt_reg) >= 12'd26)
    else $error("high-side pulse shorter than minimum on time");
  a_peak_end: assert property (
    PEAK_CURRENT_I && on_cnt_reg >= 12'd30 && calm_reg == 4'hf
      ##1 PEAK_CURRENT_I [*6] |-> !SWITCH_NODE_DRIVE_O)
    else $error("high side stayed on after peak current");
  a_ov_cut: assert property (
    OVERVOLTAGE_GUARD_RISE_I [*7] |-> !SWITCH_NODE_DRIVE_O)
    else $error("high side on above overvoltage threshold");
  a_ov_latched: assert property (
    ov_set ##1 ov_wait |-> !SWITCH_NODE_DRIVE_O)
    else $error("switching resumed before overvoltage cleared");
  a_fold_map: assert property (
    $stable(FEEDBACK_SENSE_LEVEL_I) [*8] |->
      FOLD_SHIFT_O == 2'h3 - FEEDBACK_SENSE_LEVEL_I)
    else $error("foldback shift does not match feedback level");
  a_bias_drop: assert property (
    pin_cross |-> !TIMING_SYNC_BIAS_EN_O)
    else $error("pin bias kept after first pin crossing");
  a_sync_align: assert property (
    $fell(TIMING_SYNC_PIN_I) && SYNC_LOCKED_O && FOLD_SHIFT_O == 2'h0
      |-> ##[4:10] CYCLE_START_O)
    else $error("cycle start not aligned to external falling edge");
  a_lock_time: assert property (
    $rose(SYNC_LOCKED_O) |-> acq_cnt_reg <= LOCK_CYC)
    else $error("lock took longer than the lock deadline");
endmodule

bind bscs_ctrl bscs_ctrl_monitor #(.LOCK_CYC(LOCK_CYC)) u_mon (
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .ENABLE_I(ENABLE_I),
  .THERMAL_TRIP_I(THERMAL_TRIP_I),
  .OVERVOLTAGE_GUARD_RISE_I(OVERVOLTAGE_GUARD_RISE_I),
  .OVERVOLTAGE_GUARD_CLEAR_I(OVERVOLTAGE_GUARD_CLEAR_I),
  .PEAK_CURRENT_I(PEAK_CURRENT_I),
  .FEEDBACK_SENSE_LEVEL_I(FEEDBACK_SENSE_LEVEL_I),
  .RT_PERIOD_I(RT_PERIOD_I), .TIMING_SYNC_PIN_I(TIMING_SYNC_PIN_I),
  .SWITCH_NODE_DRIVE_O(SWITCH_NODE_DRIVE_O),
  .TIMING_SYNC_BIAS_EN_O(TIMING_SYNC_BIAS_EN_O), .SS_REF_O(SS_REF_O),
  .SYNC_LOCKED_O(SYNC_LOCKED_O), .CYCLE_START_O(CYCLE_START_O),
  .FOLD_SHIFT_O(FOLD_SHIFT_O)
);

//--- tb/bscs_sync_src.sv
/*
  External system clock model driving the timing/sync pin.
  Assumes the pin reads low whenever the source is switched off.
*/
`timescale 1ns/1ps
module bscs_sync_src #(
  parameter realtime HALF_NS = 240.0
) (
  // run control
  input  wire logic run_i,
  // sync pin level
  output logic      pin_o
);
  // square wave only while running, wide halves, low in between
  initial begin
    pin_o = 1'b0;
    #1.3;
    forever begin
      wait (run_i);
      #(HALF_NS) pin_o = 1'b1;
      #(HALF_NS) pin_o = 1'b0;
    end
  end
endmodule

//--- tb/bscs_ctrl_tb.sv
/*
  Self-checking bench of the buck soft-start and sync controller.
  Assumes a 200 MHz clock, the bound checker and the sync source model.
*/
`timescale 1ns/1ps
module bscs_ctrl_tb;
  logic        clk, rst_n, en, hot, ovr, ovc, pk, pk_all, pin, run;
  logic        drv, bias, lck, cs;
  logic [1:0]  lvl, fold;
  logic [10:0] rt, ss;
  int          miscompares, checks, cyc, pk_dly, pk_end;

  bscs_ctrl #(.LOCK_CYC(600)) dut (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .ENABLE_I(en),
    .THERMAL_TRIP_I(hot), .OVERVOLTAGE_GUARD_RISE_I(ovr),
    .OVERVOLTAGE_GUARD_CLEAR_I(ovc), .PEAK_CURRENT_I(pk),
    .FEEDBACK_SENSE_LEVEL_I(lvl), .RT_PERIOD_I(rt),
    .TIMING_SYNC_PIN_I(pin), .SWITCH_NODE_DRIVE_O(drv),
    .TIMING_SYNC_BIAS_EN_O(bias), .SS_REF_O(ss), .SYNC_LOCKED_O(lck),
    .CYCLE_START_O(cs), .FOLD_SHIFT_O(fold)
  );
  bscs_sync_src u_src (.run_i(run), .pin_o(pin));

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // current sense rises pk_dly cycles into a cycle, drops at pk_end
  always @(posedge clk) begin
    #1;
    cyc = (cs === 1'b1) ? 0 : cyc + 1;
    pk = pk_all | (cyc >= pk_dly && cyc < pk_end);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input int lo, input int hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, lo[15:0]);
    end
  endtask

  task automatic gap_of(output int g);
    g = 0;
    do begin
      tick(1);
      g++;
    end while (cs !== 1'b1 && g < 5000);
  endtask

  task automatic hold_len(output int n);
    n = 0;
    while (drv === 1'b1 && n < 4000) begin
      n++;
      tick(1);
    end
  endtask

  task automatic on_len(output int n);
    gap_of(n);
    hold_len(n);
  endtask

  task automatic hi_cnt(input int span, output int n);
    n = 0;
    repeat (span) begin
      tick(1);
      n += (drv === 1'b1);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // soft-start ramp: one step per cycle, full scale, then holds
  task automatic t_ramp;
    int g;
    repeat (1023) gap_of(g);
    chk(g, 80, 80);
    tick(3);
    chk(ss, 1023, 1023);
    gap_of(g);
    tick(3);
    chk(ss, 1024, 1024);
    repeat (3) gap_of(g);
    tick(3);
    chk(ss, 1024, 1024);
  endtask

  // foldback divides the tick train by 8, 4, 2 and 1
  task automatic t_fold;
    int g;
    for (int k = 0; k < 4; k++) begin
      lvl = 2'(k);
      repeat (2) gap_of(g);
      chk(fold, 3 - k, 3 - k);
      chk(g, 80 << (3 - k), 80 << (3 - k));
    end
  endtask

  // resistor code is clamped to the 100 to 2500 kHz period range
  task automatic t_rate;
    int g;
    rt = 11'h7ff;
    gap_of(g);
    chk(g, 2000, 2000);
    rt = 11'h028;
    repeat (3) gap_of(g);
    chk(g, 80, 80);
  endtask

  // minimum on time, peak-current turn-off and pulse skipping
  task automatic t_pulse;
    int n;
    pk_dly = 2;
    repeat (2) on_len(n);
    chk(n, 27, 29);
    pk_dly = 50;
    repeat (2) on_len(n);
    chk(n, 51, 58);
    pk_all = 1'b1;
    hi_cnt(400, n);
    chk(n, 0, 0);
    pk_all = 1'b0;
    pk_dly = 40;
  endtask

  // overvoltage cuts the pulse at once and stays latched until clear
  task automatic t_ov;
    int n;
    gap_of(n);
    ovr = 1'b1;
    ovc = 1'b0;
    hold_len(n);
    chk(n, 1, 7);
    tick(8);
    ovr = 1'b0;
    hi_cnt(300, n);
    chk(n, 0, 0);
    ovc = 1'b1;
    hi_cnt(300, n);
    chk(n, 60, 300);
  endtask

  // enable loss and over-temperature stop and restart the ramp
  task automatic t_stop;
    int n;
    for (int k = 0; k < 2; k++) begin
      en = (k != 0);
      hot = (k != 0);
      hi_cnt(200, n);
      chk(n, 0, 7);
      chk(ss, 0, 0);
      en = 1'b1;
      hot = 1'b0;
      repeat (3) gap_of(n);
      tick(3);
      chk(ss, 2, 3);
    end
  endtask

  // external clock: bias off, lock, follow, then loss and fallback
  task automatic t_sync;
    int n;
    int g;
    pk_dly = 4;
    pk_end = 24;
    rt = 11'h190;
    run = 1'b1;
    n = 0;
    while (bias !== 1'b0 && n < 200) begin
      n++;
      tick(1);
    end
    chk(n, 52, 54);
    n = 0;
    while (lck !== 1'b1 && n < 700) begin
      n++;
      tick(1);
    end
    chk(n, 1, 600);
    repeat (3) gap_of(n);
    chk(n, 96, 96);
    // current already high: pulses skip, starts still follow the clock
    pk_all = 1'b1;
    gap_of(n);
    chk(n, 96, 96);
    hi_cnt(80, g);
    chk(g, 0, 0);
    pk_all = 1'b0;
    run = 1'b0;
    n = 0;
    while (lck !== 1'b0 && n < 3000) begin
      n++;
      tick(1);
    end
    chk(n, 2400, 2700);
    n = 0;
    g = 0;
    while (bias !== 1'b1 && n < 3000) begin
      n++;
      g += (cs === 1'b1);
      tick(1);
    end
    chk(g, 1, 2);
    chk(n, 1900, 2100);
    repeat (3) gap_of(n);
    chk(n, 400, 400);
  endtask

  // main sequence
  initial begin
    miscompares = 0;
    checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    en = 1'b1;
    hot = 1'b0;
    ovr = 1'b0;
    ovc = 1'b1;
    pk = 1'b0;
    pk_all = 1'b0;
    pk_dly = 40;
    pk_end = 70;
    lvl = 2'h3;
    rt = 11'h050;
    run = 1'b0;
    tick(6);
    rst_n = 1'b1;
    t_ramp;
    t_fold;
    t_rate;
    t_pulse;
    t_ov;
    t_stop;
    t_sync;
    close_out;
  end

  // watchdog a little above the expected run of about 96k cycles
  initial begin
    #495000;
    miscompares++;
    close_out;
  end
endmodule
